// [hw/mfr_host.sv]
// Host side controller of the multi-I/O read engine, APB programmed
`timescale 1ns/10ps
`include "mfr_consts.svh"
module mfr_host
   import mfr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   mfr_if.host link
);

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] op;
      logic [7:0] mode;
      logic skip;
      logic dc;
      logic [23:0] addr;
      logic [7:0] count;
      logic busy;
      logic [31:0] rdata;
      logic [7:0] left;
      mfr_host_st_t st;
      mfr_cmd_t cmd;
      logic [4:0] div;
      logic sclk;
      logic cs_n;
      logic [4:0] cnt;
      logic [23:0] sh;
      logic [3:0] io_o;
      logic [3:0] io_oe;
      logic [3:0] io_s1;
      logic [3:0] io_s2;
   } mfr_host_reg_t;

   mfr_host_reg_t s;
   mfr_host_reg_t next_s;
   logic half_end;
   logic [2:0] lanes_drv;
   logic [23:0] rx;
   logic [4:0] dlast;

   // ***************************************************************
   // Register slave and serial sequencer
   // ***************************************************************

   always_comb begin
      next_s = s;
      next_s.pready = 1'b1;
      next_s.io_s1 = link.io_lines;
      next_s.io_s2 = s.io_s1;
      half_end = s.div == 5'(`MFR_HALF_CYC - 1);
      rx = mfr_lane_in(s.sh, s.io_s2, s.cmd.data_lanes);
      dlast = s.cmd.has_mode ? `MFR_MODE_CLKS + 5'h01 : 5'h01;
      // Lanes used by the phase that drives at this falling edge
      unique case (s.st)
         MFR_H_START: lanes_drv = s.skip ? 3'h4 : 3'h1;
         MFR_H_OPC, MFR_H_WRAP: lanes_drv = 3'h1;
         MFR_H_ADDR: lanes_drv = s.cmd.addr_lanes;
         MFR_H_MODE: lanes_drv = 3'h4;
         default: lanes_drv = 3'h0;
      endcase
      // Read data is captured in setup so it stands during access
      if (psel && !penable) begin
         next_s.pslverr = 1'b0;
         unique case (paddr)
            `MFR_REG_CTRL: next_s.prdata = {14'h0000, s.dc, s.skip, s.mode,
                                            s.op};
            `MFR_REG_ADDR: next_s.prdata = {8'h00, s.addr};
            `MFR_REG_COUNT: next_s.prdata = {24'h000000, s.count};
            `MFR_REG_STATUS: next_s.prdata = {31'h00000000, s.busy};
            `MFR_REG_DATA: next_s.prdata = s.rdata;
            default: begin
               next_s.prdata = `MFR_RESET_WORD;
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      // Writes take effect in the access cycle; ignored while busy
      if (psel && penable && s.pready && pwrite && !s.busy) begin
         unique case (paddr)
            `MFR_REG_CTRL: begin
               next_s.op = pwdata[`MFR_CTRL_OP_LSB +: 8];
               next_s.mode = pwdata[`MFR_CTRL_MODE_LSB +: 8];
               next_s.skip = pwdata[`MFR_CTRL_SKIP_BIT];
               next_s.dc = pwdata[`MFR_CTRL_DC_BIT];
               if (pwdata[`MFR_CTRL_START_BIT]) begin
                  next_s.busy = 1'b1;
                  next_s.st = MFR_H_START;
                  next_s.cs_n = 1'b0;
                  next_s.div = 5'h00;
                  next_s.cnt = 5'h00;
                  next_s.left = s.count;
                  next_s.cmd = mfr_decode(pwdata[`MFR_CTRL_SKIP_BIT] ?
                     `MFR_OP_QUAD_IO : pwdata[`MFR_CTRL_OP_LSB +: 8],
                     pwdata[`MFR_CTRL_DC_BIT]);
                  next_s.sh = pwdata[`MFR_CTRL_SKIP_BIT] ? s.addr :
                     {pwdata[`MFR_CTRL_OP_LSB +: 8], 16'h0000};
               end
            end
            `MFR_REG_ADDR: next_s.addr = pwdata[23:0];
            `MFR_REG_COUNT: next_s.count = pwdata[7:0];
            default: begin
            end
         endcase
      end
      if (s.st != MFR_H_IDLE) begin
         next_s.div = half_end ? 5'h00 : s.div + 5'h01;
      end
      if (half_end && s.st == MFR_H_END) begin
         // Chip select rises half a clock after the last edge
         if (!s.cs_n) begin
            next_s.cs_n = 1'b1;
            next_s.sclk = 1'b0;
            next_s.io_oe = 4'h0;
         end else begin
            next_s.st = MFR_H_IDLE;
            next_s.busy = 1'b0;
         end
      end else if (half_end && (s.st == MFR_H_START || s.sclk)) begin
         // Falling edge: drive the next group, or release the lines
         next_s.sclk = 1'b0;
         if (s.st == MFR_H_START) begin
            next_s.st = s.skip ? MFR_H_ADDR : MFR_H_OPC;
         end
         next_s.io_oe = mfr_lane_mask(lanes_drv) &
                        {4{lanes_drv != 3'h0}};
         next_s.io_o = mfr_lane_out(s.sh, lanes_drv);
         if (lanes_drv != 3'h0) begin
            next_s.sh = s.sh << lanes_drv;
         end
      end else if (half_end && s.st != MFR_H_IDLE) begin
         // Rising edge: count the clock, sample data, change phase
         next_s.sclk = 1'b1;
         next_s.cnt = s.cnt + 5'h01;
         unique case (s.st)
            MFR_H_OPC: begin
               if (s.cnt == 5'h07) begin
                  next_s.cnt = 5'h00;
                  if (!s.cmd.valid) begin
                     next_s.st = MFR_H_END;
                  end else if (s.cmd.wrap) begin
                     next_s.st = MFR_H_WRAP;
                     next_s.sh = {s.addr[7:0], 16'h0000};
                  end else begin
                     next_s.st = MFR_H_ADDR;
                     next_s.sh = s.addr;
                  end
               end
            end
            MFR_H_ADDR: begin
               if (s.cnt == mfr_addr_last(s.cmd.addr_lanes)) begin
                  next_s.cnt = 5'h00;
                  next_s.st = s.cmd.has_mode ? MFR_H_MODE : MFR_H_DUMMY;
                  next_s.sh = {s.mode, 16'h0000};
               end
            end
            MFR_H_MODE: begin
               if (s.cnt == 5'h01) begin
                  next_s.cnt = 5'h00;
                  next_s.st = MFR_H_DUMMY;
               end
            end
            MFR_H_DUMMY: begin
               if (s.cnt == {1'b0, s.cmd.dummy} - dlast) begin
                  next_s.cnt = 5'h00;
                  next_s.st = MFR_H_DATA;
               end
            end
            MFR_H_DATA: begin
               next_s.sh = rx;
               if (s.cnt == mfr_byte_last(s.cmd.data_lanes)) begin
                  next_s.cnt = 5'h00;
                  next_s.rdata = {s.rdata[23:0], rx[7:0]};
                  next_s.left = s.left - 8'h01;
                  if (s.left == 8'h01) begin
                     next_s.st = MFR_H_END;
                  end
               end
            end
            MFR_H_WRAP: begin
               if (s.cnt == 5'h07) begin
                  next_s.st = MFR_H_END;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // State register; chip select idles high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.cs_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign link.cs_n = s.cs_n;
   assign link.sclk = s.sclk;
   assign link.host_o = s.io_o;
   assign link.host_oe = s.io_oe;

endmodule : mfr_host

// [hw/mfr_consts.svh]
// Shared constants of the multi-I/O flash read engine
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH
// Read and wrap opcodes
`define MFR_OP_DUAL_OUT 8'h3B
`define MFR_OP_DUAL_IO 8'hBB
`define MFR_OP_QUAD_OUT 8'h6B
`define MFR_OP_QUAD_IO 8'hEB
`define MFR_OP_WRAP_A 8'hC0
`define MFR_OP_WRAP_B 8'h77
// Dummy clock totals per read kind
`define MFR_DUMMY_OUT 4'h8
`define MFR_DUMMY_DIO 4'h4
`define MFR_DUMMY_DIO_LONG 4'h8
`define MFR_DUMMY_QIO 4'h6
`define MFR_DUMMY_QIO_LONG 4'hA
`define MFR_MODE_CLKS 5'h02
// Wrap code decoding
`define MFR_WRAP_OFF_NIB 4'h1
`define MFR_WRAP_MIN_LEN 24'h000008
// Host register offsets
`define MFR_REG_CTRL 12'h000
`define MFR_REG_ADDR 12'h004
`define MFR_REG_COUNT 12'h008
`define MFR_REG_STATUS 12'h00C
`define MFR_REG_DATA 12'h010
// Control field positions
`define MFR_CTRL_OP_LSB 0
`define MFR_CTRL_MODE_LSB 8
`define MFR_CTRL_SKIP_BIT 16
`define MFR_CTRL_DC_BIT 17
`define MFR_CTRL_START_BIT 31
// Reset values
`define MFR_RESET_WORD 32'h00000000
`define MFR_CS_IDLE 2'h3
// Serial clock timing
`define MFR_PCLK_NS 8
`define MFR_SCLK_HALF_NS 80
`define MFR_HALF_CYC ((`MFR_SCLK_HALF_NS + `MFR_PCLK_NS - 1) / `MFR_PCLK_NS)
`endif

// [hw/mfr_pkg.sv]
// Types and lane helpers of the multi-I/O flash read engine
`include "mfr_consts.svh"
package mfr_pkg;
   typedef enum logic [2:0] {MFR_D_IDLE, MFR_D_OPC, MFR_D_ADDR, MFR_D_DUMMY,
      MFR_D_DATA, MFR_D_WRAP, MFR_D_IGNORE} mfr_dev_st_t;
   typedef enum logic [3:0] {MFR_H_IDLE, MFR_H_START, MFR_H_OPC, MFR_H_ADDR,
      MFR_H_MODE, MFR_H_DUMMY, MFR_H_DATA, MFR_H_WRAP, MFR_H_END} mfr_host_st_t;
   typedef struct packed {
      logic valid;
      logic wrap;
      logic quad;
      logic has_mode;
      logic [2:0] addr_lanes;
      logic [2:0] data_lanes;
      logic [3:0] dummy;
   } mfr_cmd_t;

   // Command decode shared by both ends
   function automatic mfr_cmd_t mfr_decode(input logic [7:0] op,
                                           input logic dc);
      mfr_cmd_t c;
      case (op)
         `MFR_OP_DUAL_OUT: c = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 3'h2,
            `MFR_DUMMY_OUT};
         `MFR_OP_DUAL_IO: c = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 3'h2,
            dc ? `MFR_DUMMY_DIO_LONG : `MFR_DUMMY_DIO};
         `MFR_OP_QUAD_OUT: c = '{1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 3'h4,
            `MFR_DUMMY_OUT};
         `MFR_OP_QUAD_IO: c = '{1'b1, 1'b0, 1'b1, 1'b1, 3'h4, 3'h4,
            dc ? `MFR_DUMMY_QIO_LONG : `MFR_DUMMY_QIO};
         `MFR_OP_WRAP_A, `MFR_OP_WRAP_B: c = '{1'b1, 1'b1, 1'b0, 1'b0,
            3'h1, 3'h1, 4'h0};
         default: c = '0;
      endcase
      return c;
   endfunction : mfr_decode

   // Shift lane bits in at the bottom
   function automatic logic [23:0] mfr_lane_in(input logic [23:0] sh,
      input logic [3:0] io, input logic [2:0] lanes);
      case (lanes)
         3'h1: return {sh[22:0], io[0]};
         3'h2: return {sh[21:0], io[1:0]};
         default: return {sh[19:0], io};
      endcase
   endfunction : mfr_lane_in

   // Top bits of a shift word onto the lanes, line 0 lowest
   function automatic logic [3:0] mfr_lane_out(input logic [23:0] sh,
      input logic [2:0] lanes);
      case (lanes)
         3'h1: return {3'h0, sh[23]};
         3'h2: return {2'h0, sh[23:22]};
         default: return sh[23:20];
      endcase
   endfunction : mfr_lane_out

   function automatic logic [3:0] mfr_lane_mask(input logic [2:0] lanes);
      case (lanes)
         3'h1: return 4'h1;
         3'h2: return 4'h3;
         default: return 4'hF;
      endcase
   endfunction : mfr_lane_mask

   // Last clock index of a 24-bit address and of one byte
   function automatic logic [4:0] mfr_addr_last(input logic [2:0] lanes);
      case (lanes)
         3'h1: return 5'h17;
         3'h2: return 5'h0B;
         default: return 5'h05;
      endcase
   endfunction : mfr_addr_last

   function automatic logic [4:0] mfr_byte_last(input logic [2:0] lanes);
      case (lanes)
         3'h1: return 5'h07;
         3'h2: return 5'h03;
         default: return 5'h01;
      endcase
   endfunction : mfr_byte_last
endpackage : mfr_pkg

// [hw/mfr_if.sv]
// Serial flash link between host controller and read engine
`timescale 1ns/10ps
interface mfr_if;
   logic cs_n;
   logic sclk;
   logic [3:0] host_o;
   logic [3:0] host_oe;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   logic [3:0] io_lines;

   // Wire level; undriven lines float high through a pull-up
   assign io_lines = (host_oe & host_o) | (~host_oe & dev_oe & dev_o) |
                     (~host_oe & ~dev_oe);

   modport host (output cs_n, output sclk, output host_o, output host_oe,
                 input io_lines);
   modport dev (input cs_n, input sclk, input io_lines, output dev_o,
                output dev_oe);
endinterface : mfr_if

// [hw/mfr_device.sv]
// Flash side of the multi-I/O read engine
`timescale 1ns/10ps
`include "mfr_consts.svh"

// Notes on behaviour
// - 3Bh: single address, 8 dummies, dual data
// - BBh: dual address, 4 dummies, dual data
// - 6Bh needs quad enable; quad data out
// - EBh needs quad enable; quad address, 2+4 dummies
// - Dummy select gives 4/6 or 8/10
// - Sample on rising, drive on falling clock
// - Address increments per byte, wraps to 0
// - Reads ignored while internal write cycle busy
// - Host ends read by raising chip select
// - Toggling mode nibbles enter continuous mode
// - Continuous mode: frame starts with address
// - Non-toggling mode byte leaves continuous mode
// - Continuous mode only from quad I/O read
// - Host keeps mode bits uniform if unwanted
// - Host may send FFh to leave
// - Wrapping off after reset
// - C0h/77h plus wrap code, chip select framed
// - 00h-03h give 8-64 bytes, 1xh off
// - Wrap inside aligned block of chosen length
// - Wrap kept until changed; quad I/O only
module mfr_device
   import mfr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   mfr_if.dev link,
   input wire logic quad_enable_bit,
   input wire logic dummy_count_select,
   input wire logic write_busy,
   output logic [23:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic continuous_read_mode,
   output logic wrap_enabled
);

   typedef struct packed {
      logic [1:0] cs_sync;
      logic [2:0] sck_sync;
      logic [3:0] io_s1;
      logic [3:0] io_s2;
      mfr_dev_st_t st;
      mfr_cmd_t cmd;
      logic [4:0] cnt;
      logic [23:0] sh;
      logic [23:0] addr;
      logic [3:0] mode_hi;
      logic cont;
      logic wrap_en;
      logic [1:0] wrap_sel;
      logic wrap_pend;
      logic [7:0] wrap_code;
      logic [3:0] io_o;
      logic [3:0] io_oe;
   } mfr_dev_reg_t;

   mfr_dev_reg_t s;
   mfr_dev_reg_t next_s;
   logic rise;
   logic fall;
   logic [2:0] lanes_in;
   logic [23:0] shin;
   logic [23:0] src;
   logic [23:0] wmask;
   logic [23:0] inc;
   logic [23:0] next_addr;
   mfr_cmd_t dec;

   // ***************************************************************
   // Edge detection and shared datapath terms
   // ***************************************************************

   // Edges come from the second and third sync stages only
   always_comb begin
      rise = s.sck_sync[1] & ~s.sck_sync[2];
      fall = ~s.sck_sync[1] & s.sck_sync[2];
      lanes_in = (s.st == MFR_D_ADDR) ? s.cmd.addr_lanes : 3'h1;
      shin = mfr_lane_in(s.sh, s.io_s2, lanes_in);
      dec = mfr_decode(shin[7:0], dummy_count_select);
      src = (s.cnt == 5'h00) ? {rd_data, 16'h0000} : s.sh;
      wmask = (`MFR_WRAP_MIN_LEN << s.wrap_sel) - 24'h000001;
      inc = s.addr + 24'h000001;
      // Wrapped bursts stay inside the aligned block
      if (s.wrap_en && s.cmd.has_mode) begin
         next_addr = (s.addr & ~wmask) | (inc & wmask);
      end else begin
         next_addr = inc;
      end
   end

   // ***************************************************************
   // Command sequencer
   // ***************************************************************

   // One pass per pclk; link edges act only when seen after sync
   always_comb begin
      next_s = s;
      next_s.cs_sync = {s.cs_sync[0], link.cs_n};
      next_s.sck_sync = {s.sck_sync[1:0], link.sclk};
      next_s.io_s1 = link.io_lines;
      next_s.io_s2 = s.io_s1;
      if (s.cs_sync[1]) begin
         // Chip select high ends any frame and commits a wrap code
         next_s.st = MFR_D_IDLE;
         next_s.io_oe = 4'h0;
         next_s.wrap_pend = 1'b0;
         if (s.wrap_pend && s.wrap_code[7:4] == `MFR_WRAP_OFF_NIB) begin
            next_s.wrap_en = 1'b0;
         end else if (s.wrap_pend && s.wrap_code[7:2] == 6'h00) begin
            next_s.wrap_en = 1'b1;
            next_s.wrap_sel = s.wrap_code[1:0];
         end
      end else begin
         unique case (s.st)
            MFR_D_IDLE: begin
               next_s.cnt = 5'h00;
               next_s.sh = 24'h000000;
               if (write_busy) begin
                  next_s.st = MFR_D_IGNORE;
               end else if (s.cont) begin
                  // No opcode: the frame opens with the address
                  next_s.cmd = mfr_decode(`MFR_OP_QUAD_IO,
                                          dummy_count_select);
                  next_s.st = MFR_D_ADDR;
               end else begin
                  next_s.st = MFR_D_OPC;
               end
            end
            MFR_D_OPC: begin
               if (rise) begin
                  next_s.sh = shin;
                  next_s.cnt = s.cnt + 5'h01;
                  if (s.cnt == 5'h07) begin
                     next_s.cmd = dec;
                     next_s.cnt = 5'h00;
                     if (!dec.valid || (dec.quad && !quad_enable_bit)) begin
                        next_s.st = MFR_D_IGNORE;
                     end else if (dec.wrap) begin
                        next_s.st = MFR_D_WRAP;
                     end else begin
                        next_s.st = MFR_D_ADDR;
                     end
                  end
               end
            end
            MFR_D_ADDR: begin
               if (rise) begin
                  next_s.sh = shin;
                  next_s.cnt = s.cnt + 5'h01;
                  if (s.cnt == mfr_addr_last(s.cmd.addr_lanes)) begin
                     next_s.addr = shin;
                     next_s.cnt = 5'h00;
                     next_s.st = MFR_D_DUMMY;
                  end
               end
            end
            MFR_D_DUMMY: begin
               if (rise) begin
                  next_s.cnt = s.cnt + 5'h01;
                  // First two clocks of the quad I/O dummies hold the mode
                  if (s.cmd.has_mode && s.cnt == 5'h00) begin
                     next_s.mode_hi = s.io_s2;
                  end
                  if (s.cmd.has_mode && s.cnt == 5'h01) begin
                     next_s.cont = &(s.mode_hi ^ s.io_s2);
                  end
                  if (s.cnt == {1'b0, s.cmd.dummy} - 5'h01) begin
                     next_s.cnt = 5'h00;
                     next_s.st = MFR_D_DATA;
                  end
               end
            end
            MFR_D_DATA: begin
               if (fall) begin
                  next_s.io_o = mfr_lane_out(src, s.cmd.data_lanes);
                  next_s.io_oe = mfr_lane_mask(s.cmd.data_lanes);
                  next_s.sh = src << s.cmd.data_lanes;
                  next_s.cnt = s.cnt + 5'h01;
                  if (s.cnt == mfr_byte_last(s.cmd.data_lanes)) begin
                     next_s.cnt = 5'h00;
                     next_s.addr = next_addr;
                  end
               end
            end
            MFR_D_WRAP: begin
               if (rise) begin
                  next_s.sh = shin;
                  next_s.cnt = s.cnt + 5'h01;
                  if (s.cnt == 5'h07) begin
                     next_s.wrap_code = shin[7:0];
                     next_s.wrap_pend = 1'b1;
                     next_s.st = MFR_D_IGNORE;
                  end
               end
            end
            MFR_D_IGNORE: begin
               // Extra clocks are dropped until chip select rises
               next_s.io_oe = 4'h0;
            end
            default: begin
               next_s.st = MFR_D_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // State register and outputs
   // ***************************************************************

   // Reset leaves wrapping and continuous mode off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.cs_sync <= `MFR_CS_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state flops
   assign link.dev_o = s.io_o;
   assign link.dev_oe = s.io_oe;
   assign rd_addr = s.addr;
   assign continuous_read_mode = s.cont;
   assign wrap_enabled = s.wrap_en;

endmodule : mfr_device

// [testbench/mfr_chk.sv]
// Link protocol checker for the multi-I/O flash read engine
`timescale 1ns/10ps
module mfr_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] host_o,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe,
   input wire logic [3:0] io_lines
);
   // ********
   // Link rules
   // ********
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Half period of the serial clock is at least eight cycles
   sequence s_hi; sclk [*8]; endsequence
   sequence s_lo; !sclk [*8]; endsequence
   a_sclk_high: assert property ($rose(sclk) |-> s_hi)
      else $error("serial clock high phase too short");
   a_sclk_low: assert property ($fell(sclk) && !cs_n |-> s_lo)
      else $error("serial clock low phase too short");
   a_idle_clock: assert property (cs_n |-> !sclk)
      else $error("serial clock not idle outside a frame");
   a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("chip select gap too short");
   a_no_contend: assert property ((host_oe & dev_oe) == 4'h0)
      else $error("both ends drive the lines");
   // Device sees the select rise through a synchroniser
   a_dev_quiet: assert property (cs_n && $past(cs_n, 6) |-> !dev_oe)
      else $error("device drives while deselected");
   a_dev_start: assert property ($rose(|dev_oe) |-> !sclk && !cs_n)
      else $error("device starts driving outside low phase");
   a_dev_shift: assert property ($changed(dev_o) && |dev_oe &&
      $past(|dev_oe) |-> !sclk)
      else $error("device data changes while clock high");
   a_host_shift: assert property ($changed(host_o) |-> !sclk)
      else $error("host data changes while clock high");
   a_lane_set: assert property (|dev_oe |-> dev_oe inside {4'h3, 4'hF})
      else $error("device drives an odd set of lines");
endmodule : mfr_chk

// [testbench/testbench.sv]
// Bench joining the host controller and the read engine over the link
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, d;
   logic pready, pslverr, continuous_read_mode, wrap_enabled, err;
   logic quad_enable_bit = 1, dummy_count_select = 0, write_busy = 0;
   logic [23:0] rd_addr;
   logic [7:0] rd_data;
   int errors = 0, comparisons = 0, cycles = 0;
   // ********
   // Structure
   // ********
   mfr_if link ();
   mfr_host mfr_host_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .link(link));
   mfr_device mfr_device_i (.pclk, .presetn, .link(link), .quad_enable_bit,
      .dummy_count_select, .write_busy, .rd_addr, .rd_data,
      .continuous_read_mode, .wrap_enabled);
   mfr_chk mfr_chk_i (.pclk, .presetn, .cs_n(link.cs_n), .sclk(link.sclk),
      .host_o(link.host_o), .host_oe(link.host_oe), .dev_o(link.dev_o),
      .dev_oe(link.dev_oe), .io_lines(link.io_lines));
   // Array contents differ in every byte of a 64-byte block
   function automatic logic [7:0] mem(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction : mem
   assign rd_data = mem(rd_addr);
   // Four bytes from a, linear or wrapped in an aligned block of len
   function automatic logic [31:0] expw(input logic [23:0] a,
      input logic [23:0] len);
      logic [31:0] w;
      logic [23:0] x;
      w = '0;
      for (int i = 0; i < 4; i++) begin
         x = a + 24'(i);
         if (len != 0) x = (a & ~(len - 24'h1)) | (x & (len - 24'h1));
         w = {w[23:0], mem(x)};
      end
      return w;
   endfunction : expw
   task automatic test_done();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // Zero wait states are not assumed; wait for pready
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One frame, then poll busy and fetch the received word
   task automatic frame(input logic [7:0] op, input logic [7:0] mode,
      input logic skip, input logic [23:0] a);
      int k;
      k = 0;
      apb(1'b1, 12'h004, {8'h00, a});
      apb(1'b1, 12'h000, {1'b1, 13'h0, dummy_count_select, skip, mode, op});
      do begin
         apb(1'b0, 12'h00C, 32'h0);
         k++;
      end while (d[0] !== 1'b0 && k < 500);
      `CHK("busy", 1'b0, d[0])
      apb(1'b0, 12'h010, 32'h0);
   endtask : frame
   task automatic rd_chk(input logic [7:0] op, input logic [7:0] mode,
      input logic skip, input logic [23:0] a, input logic [23:0] len);
      frame(op, mode, skip, a);
      `CHK("data", expw(a, len), d)
   endtask : rd_chk
   // ********
   // Stimulus
   // ********
   always #4 pclk = ~pclk;
   // Hang guard, far above the roughly 16k cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("wrap_rst", 1'b0, wrap_enabled)
      apb(1'b1, 12'h008, 32'h4);
      // Unmapped offset answers with an error and no data
      apb(1'b0, 12'h014, 32'h0);
      `CHK("slverr", 1'b1, err)
      rd_chk(8'h3B, 8'h00, 1'b0, 24'hFFFFFE, 24'h0);
      `CHK("rd_addr", 24'h000002, rd_addr)
      rd_chk(8'hBB, 8'h00, 1'b0, 24'h001234, 24'h0);
      rd_chk(8'h6B, 8'h00, 1'b0, 24'h0ABCDE, 24'h0);
      rd_chk(8'hEB, 8'hFF, 1'b0, 24'h123456, 24'h0);
      dummy_count_select <= 1'b1;
      rd_chk(8'hBB, 8'h00, 1'b0, 24'h000100, 24'h0);
      rd_chk(8'hEB, 8'h00, 1'b0, 24'h0001F3, 24'h0);
      dummy_count_select <= 1'b0;
      rd_chk(8'hEB, 8'hA5, 1'b0, 24'h200000, 24'h0);
      `CHK("cont", 1'b1, continuous_read_mode)
      rd_chk(8'hEB, 8'h5A, 1'b1, 24'h3000F0, 24'h0);
      rd_chk(8'hEB, 8'h00, 1'b1, 24'h3000F8, 24'h0);
      `CHK("cont_off", 1'b0, continuous_read_mode)
      rd_chk(8'hBB, 8'hA5, 1'b0, 24'h000777, 24'h0);
      `CHK("cont_bb", 1'b0, continuous_read_mode)
      rd_chk(8'hEB, 8'hF0, 1'b0, 24'h000020, 24'h0);
      `CHK("cont_f0", 1'b1, continuous_read_mode)
      frame(8'hEB, 8'hFF, 1'b1, 24'hFFFFFF);
      `CHK("cont_ff", 1'b0, continuous_read_mode)
      // Both wrap opcodes, every wrap length
      for (int c = 0; c < 4; c++) begin
         frame(c[0] ? 8'h77 : 8'hC0, 8'h00, 1'b0, 24'(c));
         `CHK("wrap_on", 1'b1, wrap_enabled)
         rd_chk(8'hEB, 8'hFF, 1'b0, 24'h00053E, 24'h8 << c);
      end
      rd_chk(8'h3B, 8'h00, 1'b0, 24'h00053E, 24'h0);
      frame(8'hC0, 8'h00, 1'b0, 24'h000013);
      `CHK("wrap_off", 1'b0, wrap_enabled)
      rd_chk(8'hEB, 8'hFF, 1'b0, 24'h00053E, 24'h0);
      // Refused frames leave the lines to the pull-ups
      quad_enable_bit <= 1'b0;
      frame(8'h6B, 8'h00, 1'b0, 24'h000040);
      `CHK("no_qe", 32'hFFFFFFFF, d)
      quad_enable_bit <= 1'b1;
      write_busy <= 1'b1;
      frame(8'hEB, 8'hFF, 1'b0, 24'h000040);
      `CHK("busy_rd", 32'hFFFFFFFF, d)
      write_busy <= 1'b0;
      test_done();
   end
endmodule : testbench
